// [shared/scpr_pkg.sv]
/*
  constants for the serial configuration memory read port: pin sampling,
  state codes, access timing and default sizes.
  assumes a 10 MHz system clock and a slower config_clock from the loader.
*/
// Function
// - data output driven only while chip enable and output enable active
// - address counter advances one per config_clock rise when enabled
// - active reset level holds counter at zero and floats data
// - reset polarity set by programming; unprogrammed means active high
// - chip enable high clears counter, floats data, enters standby
// - next stored bit appears shortly after each rising config_clock
// - counting stops past last_address, data floats; last+1 wraps to zero
package scpr_pkg;
  // pins that cross into clk_sys: config_clock, chip enable, reset/oe
  localparam int SCPR_PIN_W = 3;
  localparam int SCPR_PIN_CLK = 0;
  localparam int SCPR_PIN_CE_N = 1;
  localparam int SCPR_PIN_RST = 2;
  // sync flops start at the pins' idle levels: clock low, disabled, reset;
  // a zero start would fake chip enable for two cycles after rst
  localparam logic [SCPR_PIN_W-1:0] SCPR_PIN_IDLE = 3'h6;
  // default stored bit count, a plain size of our own
  localparam int SCPR_DEPTH_DEF = 65536;
  // reset value of the programmed polarity bit: 0 means active high
  localparam logic SCPR_POL_RESET = 1'b0;
  // timing
  localparam int SCPR_SYS_CLK_NS = 100;
  localparam int SCPR_ACCESS_NS = 400;
  localparam int SCPR_ACCESS_CYC = (SCPR_ACCESS_NS / SCPR_SYS_CLK_NS < 1) ?
                                   1 : SCPR_ACCESS_NS / SCPR_SYS_CLK_NS;
  // read sequencer states
  typedef enum logic [1:0] {
    SCPR_ST_STANDBY = 2'b00,
    SCPR_ST_RESET = 2'b01,
    SCPR_ST_READ = 2'b10,
    SCPR_ST_END = 2'b11
  } scpr_state_t;
endpackage : scpr_pkg

// [core/scpr_sync.sv]
/*
  two flip-flop synchroniser for a bundle of asynchronous pins.
  assumes each bit is an independent level; no bundle coherence.
*/
`timescale 1ns/1ps
module scpr_sync #(
  parameter int WIDTH = 1,
  parameter logic [WIDTH-1:0] RST_VAL = '0
) (
  input wire logic clk, // sampling clock
  input wire logic rst, // async reset, active high
  input wire logic [WIDTH-1:0] pin_in, // raw pins
  output logic [WIDTH-1:0] pin_sync // synchronised pins
);
  logic [WIDTH-1:0] meta;

  // first stage feeds only the second stage
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      meta <= RST_VAL;
      pin_sync <= RST_VAL;
    end else begin
      meta <= pin_in;
      pin_sync <= meta;
    end
  end
endmodule : scpr_sync

// [core/scpr_read_port.sv]
/*
  read port of a one-time-programmable serial configuration memory.
  assumes the loader drives config_clock, chip_enable_n and reset_oe as
  asynchronous pins; the bench resolves the data wire from data_oe.
*/
`timescale 1ns/1ps
module scpr_read_port
  import scpr_pkg::*;
#(
  parameter int DEPTH = scpr_pkg::SCPR_DEPTH_DEF
) (
  input wire logic clk_sys, // 10 MHz system clock
  input wire logic rst, // async reset, active high
  input wire logic config_clock, // loader clock pin
  input wire logic chip_enable_n, // chip enable pin, active low
  input wire logic reset_oe, // reset/output enable pin, programmable level
  input wire logic prog_bit_we, // programmer: write one stored bit
  input wire logic [$clog2(DEPTH)-1:0] prog_addr, // programmer bit address
  input wire logic prog_bit, // programmer bit value
  input wire logic prog_pol_we, // programmer: write reset polarity
  input wire logic prog_pol_low, // 1 selects active-low reset
  output logic data_out, // serial data value
  output logic data_oe, // serial data driven when high
  output logic standby // low-current standby indicator
);
  import scpr_pkg::*;

  localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
  localparam logic [AW-1:0] LAST_ADDRESS = AW'(DEPTH - 1);

  // true when the pin sits at its reset level for the given polarity
  function automatic logic reset_level(input logic pin, input logic pol_low);
    reset_level = pol_low ? ~pin : pin;
  endfunction : reset_level

  logic [SCPR_PIN_W-1:0] pins_s;
  logic clk_prev;
  logic pol_low;
  logic [AW-1:0] addr;
  scpr_state_t state;
  scpr_state_t next_state;
  logic clk_rise;
  logic ce_act;
  logic rst_act;
  logic mem [DEPTH];

  // all three pins are asynchronous to clk_sys
  scpr_sync #(
    .WIDTH(SCPR_PIN_W),
    .RST_VAL(SCPR_PIN_IDLE)
  ) u_sync (
    .clk(clk_sys),
    .rst(rst),
    .pin_in({reset_oe, chip_enable_n, config_clock}),
    .pin_sync(pins_s)
  );

  // edge finder works on the second stage only
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      clk_prev <= 1'b0;
    end else begin
      clk_prev <= pins_s[SCPR_PIN_CLK];
    end
  end

  assign clk_rise = pins_s[SCPR_PIN_CLK] & ~clk_prev;
  assign ce_act = ~pins_s[SCPR_PIN_CE_N];
  assign rst_act = reset_level(pins_s[SCPR_PIN_RST], pol_low);

  // polarity is fixed by programming; unprogrammed parts reset active high
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      pol_low <= SCPR_POL_RESET;
    end else if (prog_pol_we) begin
      pol_low <= prog_pol_low;
    end
  end

  // programming path; kept simple, the real one is off-chip algorithm
  always_ff @(posedge clk_sys) begin
    if (prog_bit_we) begin
      mem[prog_addr] <= prog_bit;
    end
  end

  // sequencer: reset wins over standby so the counter is always held
  always_comb begin
    next_state = state;
    case (state)
      SCPR_ST_STANDBY,
      SCPR_ST_RESET: begin
        next_state = SCPR_ST_READ;
      end
      SCPR_ST_READ: begin
        if (clk_rise && addr == LAST_ADDRESS) begin
          next_state = SCPR_ST_END;
        end
      end
      SCPR_ST_END: begin
        next_state = SCPR_ST_END;
      end
      default: begin
        next_state = SCPR_ST_STANDBY;
      end
    endcase
    if (rst_act) begin
      next_state = SCPR_ST_RESET;
    end else if (!ce_act) begin
      next_state = SCPR_ST_STANDBY;
    end
  end

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      state <= SCPR_ST_STANDBY;
    end else begin
      state <= next_state;
    end
  end

  // address counter; a counted edge at the last address wraps to zero
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      addr <= '0;
    end else if (rst_act || !ce_act) begin
      addr <= '0;
    end else if (clk_rise && state == SCPR_ST_READ) begin
      // one step per edge, ascending, never past the array
      addr <= (addr == LAST_ADDRESS) ? '0 : addr + AW'(1);
    end
  end

  // data and its enable are registered, about four cycles after the pin edge
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      data_out <= 1'b0;
      data_oe <= 1'b0;
    end else begin
      data_out <= mem[addr];
      // drive only when enabled, out of reset and not past the end
      data_oe <= ce_act && !rst_act && next_state == SCPR_ST_READ
                 && state == SCPR_ST_READ;
    end
  end

  // standby follows chip enable; reset alone does not cut the current
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      standby <= 1'b1;
    end else begin
      standby <= !ce_act;
    end
  end

  // checks
  a_data_gated: assert property (@(posedge clk_sys) disable iff (rst)
    data_oe |-> $past(ce_act) && !$past(rst_act))
    else $error("data driven while disabled");

  a_addr_step: assert property (@(posedge clk_sys) disable iff (rst)
    clk_rise && ce_act && !rst_act && state == SCPR_ST_READ
    |=> addr == (($past(addr) == LAST_ADDRESS) ? '0 : $past(addr) + AW'(1)))
    else $error("address did not step on a counted edge");

  a_reset_hold: assert property (@(posedge clk_sys) disable iff (rst)
    rst_act |=> addr == '0 ##1 !data_oe)
    else $error("reset did not hold counter and float data");

  a_pol_fixed: assert property (@(posedge clk_sys) disable iff (rst)
    !prog_pol_we |=> $stable(pol_low))
    else $error("reset polarity changed without programming");

  a_standby_clear: assert property (@(posedge clk_sys) disable iff (rst)
    !ce_act |=> standby && addr == '0 && !data_oe)
    else $error("chip enable high did not clear and idle");

  a_access_time: assert property (@(posedge clk_sys) disable iff (rst)
    data_oe && $past(data_oe) |-> data_out == mem[$past(addr)])
    else $error("data does not match stored bit");

  a_end_freeze: assert property (@(posedge clk_sys) disable iff (rst)
    state == SCPR_ST_END && ce_act && !rst_act
    |=> $stable(addr) ##1 !data_oe)
    else $error("counter moved or data driven past last address");

  a_no_idle_step: assert property (@(posedge clk_sys) disable iff (rst)
    !clk_rise && ce_act && !rst_act |=> $stable(addr))
    else $error("address moved without a clock edge");

  a_addr_range: assert property (@(posedge clk_sys) disable iff (rst)
    addr <= LAST_ADDRESS)
    else $error("address beyond stored bits");

  c_reach_end: cover property (@(posedge clk_sys) disable iff (rst)
    state == SCPR_ST_READ ##1 state == SCPR_ST_END);
  c_reset_mid: cover property (@(posedge clk_sys) disable iff (rst)
    data_oe ##1 rst_act);
  c_standby: cover property (@(posedge clk_sys) disable iff (rst)
    data_oe ##1 !ce_act ##2 standby);
  c_active_low: cover property (@(posedge clk_sys) disable iff (rst)
    pol_low && data_oe);
endmodule : scpr_read_port

// [dv/scpr_loader.sv]
/*
  loader model: drives config_clock, enable and restart pins of the memory.
  assumes a pull-up on the loader data input while the memory floats it.
*/
`timescale 1ns/1ps
module scpr_loader (
  input wire logic data_out, // memory data value
  input wire logic data_oe, // memory drives data
  input wire logic pol_low, // restart pin active low
  output logic config_clock, // loader clock, still between frames
  output logic chip_enable_n, // completion line into enable
  output logic reset_oe, // restart line into reset
  output logic din // resolved data wire
);
  // pull-up wins when nobody drives, so a float reads as 1
  assign din = data_oe ? data_out : 1'b1;
  initial begin
    config_clock = 1'b0;
    chip_enable_n = 1'b1;
    reset_oe = 1'b1;
  end
  // restart line into the reset pin at the programmed level
  task automatic restart(input logic on);
    reset_oe = on ^ pol_low;
  endtask : restart
  // completion line: disable the memory when done
  task automatic enable(input logic on);
    chip_enable_n = ~on;
  endtask : enable
  // exactly n rising edges at 800 ns, low when idle
  task automatic pulses(input int n);
    repeat (n) begin
      #400 config_clock = 1'b1;
      #400 config_clock = 1'b0;
    end
  endtask : pulses
endmodule : scpr_loader

// [dv/scpr_read_port_bench.sv]
/*
  self-checking bench for the memory read port with a 16-bit stream.
  assumes the loader model in dv/ and the design files in core/.
*/
`timescale 1ns/1ps
module scpr_read_port_bench;
  localparam int DEPTH = 16;
  logic clk_sys, rst, prog_bit_we, prog_bit, prog_pol_we, prog_pol_low;
  logic [3:0] prog_addr;
  logic config_clock, chip_enable_n, reset_oe, data_out, data_oe;
  logic standby, din, pol_now;
  logic [DEPTH-1:0] mem;
  logic [1:0] exp_q[$];
  int n_fail = 0;
  int comparisons = 0;
  scpr_read_port #(.DEPTH(DEPTH)) u_dut (.clk_sys(clk_sys), .rst(rst),
    .config_clock(config_clock), .chip_enable_n(chip_enable_n),
    .reset_oe(reset_oe), .prog_bit_we(prog_bit_we), .prog_addr(prog_addr),
    .prog_bit(prog_bit), .prog_pol_we(prog_pol_we),
    .prog_pol_low(prog_pol_low), .data_out(data_out), .data_oe(data_oe),
    .standby(standby));
  scpr_loader u_ldr (.data_out(data_out), .data_oe(data_oe),
    .pol_low(pol_now), .config_clock(config_clock),
    .chip_enable_n(chip_enable_n), .reset_oe(reset_oe), .din(din));
  task automatic check(input logic [1:0] seen, input logic [1:0] want);
    comparisons++;
    if (seen !== want) begin
      n_fail++;
      $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, want);
    end
  endtask : check
  task automatic wrap_up();
    $display("comparisons=%0d n_fail=%0d", comparisons, n_fail);
    if (n_fail == 0 && comparisons > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask : wrap_up
  // inputs move a fixed 1 ns after the clock edge
  task automatic tick(input int n);
    repeat (n) @(posedge clk_sys);
    #1;
  endtask : tick
  // note n stored bits from address 0, then floats for edges past them
  task automatic read_run(input int n, input int flt);
    for (int i = 0; i < n; i++) exp_q.push_back({1'b1, mem[i]});
    repeat (flt) exp_q.push_back(2'b01);
    u_ldr.pulses(n + flt);
  endtask : read_run
  initial begin
    clk_sys = 1'b0;
    forever #50 clk_sys = ~clk_sys;
  end
  // the loader samples the wire at each rising config_clock
  always @(posedge config_clock) begin
    if (exp_q.size() != 0) begin
      check({data_oe, din}, exp_q.pop_front());
    end else begin
      check({data_oe, din}, 2'bxx);
    end
  end
  // a hang counts as a mismatch
  initial begin
    repeat (20000) @(posedge clk_sys);
    n_fail++;
    wrap_up();
  end
  initial begin
    rst = 1'b1;
    prog_bit_we = 1'b0;
    prog_pol_we = 1'b0;
    pol_now = 1'b0;
    void'($urandom(32'h97ec6eae));
    prog_bit = 1'($urandom);
    prog_addr = 4'($urandom);
    prog_pol_low = 1'($urandom);
    mem = DEPTH'($urandom);
    tick(5);
    rst = 1'b0;
    for (int i = 0; i < DEPTH; i++) begin
      prog_addr = i[3:0];
      prog_bit = mem[i];
      prog_bit_we = 1'b1;
      tick(1);
    end
    prog_bit_we = 1'b0;
    // strobes low: stray address, bit and polarity must not land
    prog_addr = 4'($urandom);
    prog_bit = 1'($urandom);
    prog_pol_low = 1'($urandom);
    tick(4);
    check({standby, data_oe}, 2'b10);
    u_ldr.restart(1'b0);
    u_ldr.enable(1'b1);
    tick(8);
    read_run(DEPTH, 2);
    // reset held: edges refused, counter back to zero after release
    u_ldr.restart(1'b1);
    tick(4);
    check({standby, data_oe}, 2'b00);
    read_run(0, 2);
    u_ldr.restart(1'b0);
    tick(8);
    read_run(5, 0);
    // enable dropped mid-stream: standby, then restart from zero
    u_ldr.enable(1'b0);
    tick(4);
    check({standby, data_oe}, 2'b10);
    read_run(0, 2);
    u_ldr.enable(1'b1);
    tick(8);
    read_run(3, 0);
    // switch the restart pin to active low
    prog_pol_low = 1'b1;
    pol_now = 1'b1;
    prog_pol_we = 1'b1;
    tick(1);
    prog_pol_we = 1'b0;
    u_ldr.restart(1'b1);
    tick(4);
    read_run(0, 2);
    u_ldr.restart(1'b0);
    tick(8);
    read_run(4, 0);
    u_ldr.enable(1'b0);
    tick(4);
    check({standby, data_oe}, 2'b10);
    check({1'b0, exp_q.size() != 0}, 2'b00);
    wrap_up();
  end
endmodule : scpr_read_port_bench
